// >>> design/vector_decode_core.sv
`timescale 1ns/10ps
// Summary of operation
// - Format 1: whole opcode byte, operand ignored
// - Format 2: top operand nibble, 4-bit operator
// - Format 3: fetch second byte as operand
// - Format 4: partial with nibble, finish with byte
// - Words split into high, middle, low nibbles
// - Negative flag follows accumulator MSB
// - Shift-out flag and vector-busy flag kept
// - Equal, less-than and carry flags kept
// - Alternate accumulator for next instruction only
// - Paged load from page and nibble address
// - Previous-address load reuses scratch address
// - Nibble load-immediate fills top, clears rest
// - Paged store keeps negative flag
// - Previous-address store leaves flags alone
// - Paged or previous add, sets negative, carry
// - Nibble add-immediate sets negative and carry
// - Zero nibble means operand in next byte
// - Byte add-immediate adds second byte
// - Multiply step shifts both, conditional add
// - Paged or previous subtract, negative, carry
// - Nibble subtract-immediate sets negative flag
// - Byte subtract-immediate sets negative, carry
// - Page register holds high address bits
module vector_decode_core
  import vec_pkg::*;
#(
  parameter int PAGE_W = 4  // High part of a paged scratch address
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [REG_DW-1:0] reg_rdata_q,
  output logic [PC_W-1:0] rom_addr_q,
  output logic rom_rd_q,
  input wire logic [7:0] rom_rdata,
  output logic [PAGE_W+3:0] ram_addr_q,
  output logic ram_rd_q,
  output logic ram_wr_q,
  output logic [DATA_W-1:0] ram_wdata_q,
  input wire logic [DATA_W-1:0] ram_rdata,
  input wire logic vector_done,
  output logic [DATA_W-1:0] acc_primary_q,
  output logic [DATA_W-1:0] acc_alt_q,
  output logic negative_flag_q,
  output logic carry_flag_q,
  output logic equal_flag_q,
  output logic less_than_flag_q,
  output logic right_shift_flag_q,
  output logic vector_in_process_flag_q,
  output logic [PC_W-1:0] pc_q,
  output logic [PC_W-1:0] prog_addr_q
);

  // Address must at least hold the page and stay byte-sized
  if (PAGE_W < 1 || PAGE_W > 4) begin : g_bad_page
    $error("PAGE_W must lie between 1 and 4");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Classify a first instruction byte into its format
  function automatic fmt_t fmt_of(input logic [7:0] b);
    fmt_t f;
    f = FMT_NONE;
    // Zero operand nibble on add/sub immediates flags a second byte
    if (b == OP_BYTE_ADD_IMM || b == OP_BYTE_SUB_IMM) begin
      f = FMT_BYTE;
    end else if (b[7:4] inside {NIB_LOAD_PAGE, NIB_ADD_IMM, NIB_SUB_IMM,
                                NIB_PAGED_ADD, NIB_PAGED_SUB, NIB_LOAD_IMM,
                                NIB_PAGED_STORE, NIB_PAGED_LOAD}) begin
      f = FMT_NIBBLE;
    end else if (b[3:0] == NIB_PROG_ADDR_IMM) begin
      f = FMT_WIDE;
    end
    return f;
  endfunction

  // Nibble-format opcodes that read a paged scratch word
  function automatic logic paged_read(input logic [7:0] b);
    return b[7:4] inside {NIB_PAGED_LOAD, NIB_PAGED_ADD, NIB_PAGED_SUB};
  endfunction

  // Single-word opcodes that reuse the held scratch address
  function automatic logic prev_read(input logic [7:0] b);
    return b inside {OP_PREV_ADDR_LOAD, OP_PREV_ADDR_ADD,
                     OP_PREV_ADDR_SUBTRACT, OP_MULTIPLY_STEP};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  state_t state_q;
  logic [7:0] ir_q;            // Instruction register
  logic [7:0] dar_q;           // Data and address register
  fmt_t fmt_q;                 // Format of the held instruction
  logic [PAGE_W-1:0] page_q;   // Page register
  logic alt_pend_q;            // Last decoded byte was the select
  logic use_alt_q;             // Current instruction uses alternate
  logic run_q;                 // Software run enable
  fmt_t dec_fmt;               // Format of the byte arriving now
  logic [DATA_W-1:0] target;   // Selected accumulator

  assign dec_fmt = fmt_of(rom_rdata);
  assign target = use_alt_q ? acc_alt_q : acc_primary_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register port: run bit in, state out, data one cycle after strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      run_q <= 1'b0;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      run_q <= reg_wdata[CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: reg_rdata_q <= {31'h0000_0000, run_q};
        REG_FLAGS: begin
          reg_rdata_q <= {26'h000_0000, vector_in_process_flag_q,
                          right_shift_flag_q, negative_flag_q, carry_flag_q,
                          less_than_flag_q, equal_flag_q};
        end
        REG_ACCS: reg_rdata_q <= {8'h00, acc_alt_q, acc_primary_q};
        default: reg_rdata_q <= {8'h00, prog_addr_q, pc_q};
      endcase
    end else begin
      // Data stand only in the cycle after the strobe
      reg_rdata_q <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: fetch, decode, optional second byte, optional scratch read
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= ST_FETCH;
      pc_q <= PC_RESET;
      rom_addr_q <= PC_RESET;
      rom_rd_q <= 1'b0;
      ram_addr_q <= '0;
      ram_rd_q <= 1'b0;
      ram_wr_q <= 1'b0;
      ram_wdata_q <= '0;
      ir_q <= 8'h00;
      dar_q <= 8'h00;
      fmt_q <= FMT_NONE;
      page_q <= '0;
      prog_addr_q <= PC_RESET;
    end else begin
      // Memory strobes are single-cycle pulses
      rom_rd_q <= 1'b0;
      ram_rd_q <= 1'b0;
      ram_wr_q <= 1'b0;
      case (state_q)
        ST_FETCH: begin
          // Finish the instruction in flight before honouring a stop
          if (run_q) begin
            rom_addr_q <= pc_q;
            rom_rd_q <= 1'b1;
            pc_q <= pc_q + 12'h001;
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          state_q <= ST_DECODE;
        end
        ST_DECODE: begin
          ir_q <= rom_rdata;
          fmt_q <= dec_fmt;
          state_q <= ST_FETCH;
          case (dec_fmt)
            FMT_BYTE, FMT_WIDE: begin
              // Second byte of the instruction, counted like any fetch
              rom_addr_q <= pc_q;
              rom_rd_q <= 1'b1;
              pc_q <= pc_q + 12'h001;
              state_q <= ST_WAIT2;
              if (dec_fmt == FMT_WIDE) begin
                // Top four bits of the wide operand land now
                prog_addr_q[11:8] <= rom_rdata[7:4];
              end
            end
            FMT_NIBBLE: begin
              // Operand sits in the top of the data register
              dar_q <= {rom_rdata[3:0], 4'h0};
              if (rom_rdata[7:4] == NIB_LOAD_PAGE) begin
                page_q <= rom_rdata[PAGE_W-1:0];
              end else if (rom_rdata[7:4] == NIB_PAGED_STORE) begin
                ram_addr_q <= {page_q, rom_rdata[3:0]};
                ram_wdata_q <= alt_pend_q ? acc_alt_q : acc_primary_q;
                ram_wr_q <= 1'b1;
              end else if (paged_read(rom_rdata)) begin
                ram_addr_q <= {page_q, rom_rdata[3:0]};
                ram_rd_q <= 1'b1;
                state_q <= ST_RAM_WAIT;
              end else begin
                state_q <= ST_EXEC;
              end
            end
            default: begin
              // Whole byte is the operation; data register untouched
              if (rom_rdata == OP_PREV_ADDR_STORE) begin
                ram_wdata_q <= alt_pend_q ? acc_alt_q : acc_primary_q;
                ram_wr_q <= 1'b1;
              end else if (prev_read(rom_rdata)) begin
                // Scratch address stays as the last access left it
                ram_rd_q <= 1'b1;
                state_q <= ST_RAM_WAIT;
              end
            end
          endcase
        end
        ST_WAIT2: begin
          state_q <= ST_OPERAND;
        end
        ST_OPERAND: begin
          dar_q <= rom_rdata;
          if (fmt_q == FMT_WIDE) begin
            prog_addr_q[7:0] <= rom_rdata;
            state_q <= ST_FETCH;
          end else begin
            state_q <= ST_EXEC;
          end
        end
        ST_RAM_WAIT: begin
          state_q <= ST_EXEC;
        end
        default: begin
          state_q <= ST_FETCH;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alternate accumulator lasts for exactly one following instruction
  always_ff @(posedge clk) begin
    if (!nrst) begin
      alt_pend_q <= 1'b0;
      use_alt_q <= 1'b0;
    end else if (state_q == ST_DECODE) begin
      alt_pend_q <= (rom_rdata == OP_SELECT_ALT);
      use_alt_q <= alt_pend_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execution decode of the held instruction
  alu_op_t alu_op;
  logic [DATA_W-1:0] alu_a;
  logic [DATA_W-1:0] alu_b;
  logic [DATA_W-1:0] alu_res;
  logic alu_carry;
  logic alu_eq;
  logic alu_lt;
  logic wr_acc;     // Result goes to the selected accumulator
  logic upd_neg;    // Negative flag follows the result
  logic upd_cy;     // Carry flag follows the adder
  logic upd_cmp;    // Equal and less-than follow the comparator
  logic is_mul;     // Multiply step in progress
  logic mul_out;    // Bit shifted out of the primary accumulator
  logic [DATA_W-1:0] alt_shift;

  assign mul_out = acc_primary_q[0];
  assign alt_shift = {acc_alt_q[DATA_W-1], acc_alt_q[DATA_W-1:1]};

  always_comb begin
    alu_op = ALU_PASS;
    alu_a = target;
    alu_b = ram_rdata;
    wr_acc = 1'b0;
    upd_neg = 1'b0;
    upd_cy = 1'b0;
    upd_cmp = 1'b0;
    is_mul = 1'b0;
    if (state_q == ST_EXEC) begin
      case (fmt_q)
        FMT_NIBBLE: begin
          wr_acc = 1'b1;
          upd_neg = 1'b1;
          case (ir_q[7:4])
            // High nibble gets the data, middle and low nibbles cleared
            NIB_LOAD_IMM: alu_b = {dar_q[7:4], 8'h00};
            NIB_ADD_IMM: begin
              alu_op = ALU_ADD;
              alu_b = {8'h00, dar_q[7:4]};
              upd_cy = 1'b1;
              upd_cmp = 1'b1;
            end
            NIB_SUB_IMM: begin
              alu_op = ALU_SUB;
              alu_b = {8'h00, dar_q[7:4]};
              upd_cmp = 1'b1;
            end
            NIB_PAGED_ADD: begin
              alu_op = ALU_ADD;
              upd_cy = 1'b1;
              upd_cmp = 1'b1;
            end
            NIB_PAGED_SUB: begin
              alu_op = ALU_SUB;
              upd_cy = 1'b1;
              upd_cmp = 1'b1;
            end
            default: ;  // Paged load passes the scratch word
          endcase
        end
        FMT_BYTE: begin
          // Byte immediates: whole second byte is the operand
          alu_op = (ir_q == OP_BYTE_ADD_IMM) ? ALU_ADD : ALU_SUB;
          alu_b = {4'h0, dar_q};
          wr_acc = 1'b1;
          upd_neg = 1'b1;
          upd_cy = 1'b1;
          upd_cmp = 1'b1;
        end
        FMT_NONE: begin
          case (ir_q)
            OP_PREV_ADDR_LOAD: begin
              wr_acc = 1'b1;
              upd_neg = 1'b1;
            end
            OP_PREV_ADDR_ADD, OP_PREV_ADDR_SUBTRACT: begin
              alu_op = (ir_q == OP_PREV_ADDR_ADD) ? ALU_ADD : ALU_SUB;
              wr_acc = 1'b1;
              upd_neg = 1'b1;
              upd_cy = 1'b1;
              upd_cmp = 1'b1;
            end
            OP_MULTIPLY_STEP: begin
              // Adder serves the shifted alternate; zero when nothing fell out
              is_mul = 1'b1;
              alu_op = ALU_ADD;
              alu_a = alt_shift;
              alu_b = mul_out ? ram_rdata : '0;
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end
  end

  alu_unit u_alu (
    .op(alu_op),
    .a(alu_a),
    .b(alu_b),
    .res(alu_res),
    .carry(alu_carry),
    .equal(alu_eq),
    .less(alu_lt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Accumulators
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc_primary_q <= ACC_RESET;
      acc_alt_q <= ACC_RESET;
    end else if (is_mul) begin
      // Both shift together; the alternate's low bit feeds the primary
      acc_primary_q <= {acc_alt_q[0], acc_primary_q[DATA_W-1:1]};
      acc_alt_q <= alu_res;
    end else if (wr_acc && use_alt_q) begin
      acc_alt_q <= alu_res;
    end else if (wr_acc) begin
      acc_primary_q <= alu_res;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition flags; stores and the select leave them alone
  always_ff @(posedge clk) begin
    if (!nrst) begin
      negative_flag_q <= 1'b0;
      carry_flag_q <= 1'b0;
      equal_flag_q <= 1'b0;
      less_than_flag_q <= 1'b0;
      right_shift_flag_q <= 1'b0;
    end else begin
      if (upd_neg || is_mul) begin
        negative_flag_q <= alu_res[DATA_W-1];
      end
      if (upd_cy) begin
        carry_flag_q <= alu_carry;
      end
      if (upd_cmp) begin
        equal_flag_q <= alu_eq;
        less_than_flag_q <= alu_lt;
      end
      if (is_mul) begin
        right_shift_flag_q <= mul_out;
      end
    end
  end

  // Vector busy: draw sets it, the display's done pulse clears; set wins
  always_ff @(posedge clk) begin
    if (!nrst) begin
      vector_in_process_flag_q <= 1'b0;
    end else if (state_q == ST_DECODE && rom_rdata == OP_DRAW_VECTOR) begin
      vector_in_process_flag_q <= 1'b1;
    end else if (vector_done) begin
      vector_in_process_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  logic in_dec;
  assign in_dec = (state_q == ST_DECODE);

  a_fetch_advance: assert property (state_q == ST_FETCH && run_q |=>
    rom_rd_q && rom_addr_q == $past(pc_q) && pc_q == $past(pc_q) + 12'h001)
    else $error("fetch did not read and advance pc");
  a_second_byte: assert property (in_dec && dec_fmt == FMT_BYTE |=>
    rom_rd_q ##1 state_q == ST_OPERAND ##1 state_q == ST_EXEC && dar_q == $past(rom_rdata))
    else $error("second byte not taken as operand");
  a_wide_operand: assert property (in_dec && dec_fmt == FMT_WIDE |=>
    ##2 prog_addr_q == {$past(rom_rdata[7:4], 3), $past(rom_rdata)})
    else $error("wide operand not assembled");
  a_paged_addr: assert property (in_dec && paged_read(rom_rdata) |=>
    ram_rd_q && ram_addr_q == {$past(page_q), $past(rom_rdata[3:0])})
    else $error("paged address wrong");
  a_prev_addr_kept: assert property (in_dec && prev_read(rom_rdata) |=>
    ram_rd_q && $stable(ram_addr_q))
    else $error("previous address changed");
  a_store_flags: assert property (ram_wr_q |->
    $stable(negative_flag_q) && $stable(carry_flag_q) && $stable(equal_flag_q))
    else $error("store changed flags");
  a_nibble_load_immediate_clear: assert property (state_q == ST_EXEC && fmt_q == FMT_NIBBLE
    && ir_q[7:4] == NIB_LOAD_IMM |=> target == {$past(dar_q[7:4]), 8'h00}
    && negative_flag_q == $past(dar_q[7]))
    else $error("load immediate wrong");
  a_arith_neg: assert property (state_q == ST_EXEC && upd_cy |=>
    negative_flag_q == target[DATA_W-1] && carry_flag_q == $past(alu_carry))
    else $error("negative flag not the result msb");
  a_alt_one_shot: assert property (state_q == ST_EXEC && !use_alt_q && !is_mul
    |=> $stable(acc_alt_q))
    else $error("alternate written without select");
  a_mul_shift: assert property (is_mul |=>
    right_shift_flag_q == $past(acc_primary_q[0])
    && acc_primary_q[10:0] == $past(acc_primary_q[11:1]))
    else $error("multiply step shift wrong");

  c_byte_add: cover property (state_q == ST_EXEC && ir_q == OP_BYTE_ADD_IMM);
  c_mul_add: cover property (is_mul && mul_out);
  c_alt_store: cover property (in_dec && alt_pend_q && rom_rdata == OP_PREV_ADDR_STORE);
  c_vector_busy: cover property (vector_in_process_flag_q ##1 !vector_in_process_flag_q);

endmodule // vector_decode_core

// >>> common/vec_pkg.sv
package vec_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int DATA_W = 12;  // Accumulator and scratch word width
  localparam int PC_W = 12;    // Program address width
  localparam int REG_AW = 2;   // Register port address width
  localparam int REG_DW = 32;  // Register port data width

  ////////////////////////////////////////////////////////////////////////////
  // Full-byte opcodes (single word unless noted)
  localparam logic [7:0] OP_SELECT_ALT = 8'h57;
  localparam logic [7:0] OP_MULTIPLY_STEP = 8'hE3;
  localparam logic [7:0] OP_PREV_ADDR_ADD = 8'hE7;
  localparam logic [7:0] OP_PREV_ADDR_SUBTRACT = 8'hE8;
  localparam logic [7:0] OP_PREV_ADDR_LOAD = 8'hEA;
  localparam logic [7:0] OP_PREV_ADDR_STORE = 8'hEC;
  localparam logic [7:0] OP_DRAW_VECTOR = 8'hEE;
  localparam logic [7:0] OP_BYTE_ADD_IMM = 8'h20;  // Second byte follows
  localparam logic [7:0] OP_BYTE_SUB_IMM = 8'h30;  // Second byte follows

  // Nibble operators in bits 7..4, operand nibble in bits 3..0
  localparam logic [3:0] NIB_LOAD_PAGE = 4'h1;
  localparam logic [3:0] NIB_ADD_IMM = 4'h2;
  localparam logic [3:0] NIB_SUB_IMM = 4'h3;
  localparam logic [3:0] NIB_PAGED_ADD = 4'h6;
  localparam logic [3:0] NIB_PAGED_SUB = 4'h7;
  localparam logic [3:0] NIB_LOAD_IMM = 4'h8;
  localparam logic [3:0] NIB_PAGED_STORE = 4'h9;
  localparam logic [3:0] NIB_PAGED_LOAD = 4'hA;
  // Wide-operand operator sits in bits 3..0
  localparam logic [3:0] NIB_PROG_ADDR_IMM = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [PC_W-1:0] PC_RESET = 12'h000;
  localparam logic [DATA_W-1:0] ACC_RESET = 12'h000;

  // Register port indices
  localparam logic [REG_AW-1:0] REG_CTRL = 2'h0;
  localparam logic [REG_AW-1:0] REG_FLAGS = 2'h1;
  localparam logic [REG_AW-1:0] REG_ACCS = 2'h2;
  localparam logic [REG_AW-1:0] REG_ADDRS = 2'h3;
  localparam int CTRL_RUN_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {ALU_PASS, ALU_ADD, ALU_SUB} alu_op_t;
  typedef enum logic [1:0] {FMT_NONE, FMT_NIBBLE, FMT_BYTE, FMT_WIDE} fmt_t;
  typedef enum logic [2:0] {
    ST_FETCH, ST_WAIT, ST_DECODE, ST_WAIT2, ST_OPERAND, ST_RAM_WAIT, ST_EXEC
  } state_t;

endpackage

// >>> design/alu_unit.sv
`timescale 1ns/10ps
module alu_unit
  import vec_pkg::*;
(
  input alu_op_t op,
  input wire logic [DATA_W-1:0] a,
  input wire logic [DATA_W-1:0] b,
  output logic [DATA_W-1:0] res,
  output logic carry,
  output logic equal,
  output logic less
);

  // One extra bit holds the carry out
  logic [DATA_W:0] sum;

  ////////////////////////////////////////////////////////////////////////////
  // Sum, difference or plain pass of b
  always_comb begin
    sum = '0;
    case (op)
      ALU_ADD: begin
        sum = {1'b0, a} + {1'b0, b};
      end
      // Carry set means no borrow, as two's complement add of ~b
      ALU_SUB: begin
        sum = {1'b0, a} + {1'b0, ~b} + 13'h0001;
      end
      default: begin
        sum = {1'b0, b};
      end
    endcase
  end

  assign res = sum[DATA_W-1:0];
  assign carry = sum[DATA_W];
  // Magnitude compare, not signed: branch logic wants unsigned order
  assign equal = (a == b);
  assign less = (b < a);

endmodule // alu_unit

// >>> tb/mem_model.sv
`timescale 1ns/10ps
module mem_model
  import vec_pkg::*;
(
  input wire logic clk,
  input wire logic [PC_W-1:0] rom_addr_q,
  input wire logic rom_rd_q,
  output logic [7:0] rom_rdata,
  input wire logic [7:0] ram_addr_q,
  input wire logic ram_rd_q,
  input wire logic ram_wr_q,
  input wire logic [DATA_W-1:0] ram_wdata_q,
  output logic [DATA_W-1:0] ram_rdata
);
  logic [7:0] rom [4096];  // Program bytes, loaded by the bench
  logic [DATA_W-1:0] ram [256];  // Scratch words
  initial begin
    rom_rdata = 8'h00;
    ram_rdata = 12'h000;
  end
  // Data stand only the cycle after a strobe; inverted otherwise so stale values never match
  always @(posedge clk) begin
    rom_rdata <= rom_rd_q ? rom[rom_addr_q] : ~rom_rdata;
    ram_rdata <= ram_rd_q ? ram[ram_addr_q] : ~ram_rdata;
    if (ram_wr_q) begin
      ram[ram_addr_q] <= ram_wdata_q;
    end
  end
endmodule  // mem_model

// >>> tb/vector_cpu_decode_alu_ops_bench.sv
`timescale 1ns/10ps
module vector_cpu_decode_alu_ops_bench;
  import vec_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic vector_done = 1'b0;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [REG_DW-1:0] reg_wdata = '0;
  logic [REG_DW-1:0] reg_rdata_q;
  logic [PC_W-1:0] rom_addr_q, pc_q, pa_q;
  logic [7:0] rom_rdata, ram_addr_q;
  logic rom_rd_q, ram_rd_q, ram_wr_q, neg_q, cy_q, eq_q, lt_q, rs_q, vt_q;
  logic [DATA_W-1:0] ram_wdata_q, ram_rdata, acc_primary_q, acc_alt_q;
  int n_mismatch = 0;
  int n_compared = 0;
  // Reference machine state
  int ap, aa, neg, cy, eq, lt, rs, vt, pg, wsa, sel, arm, pa;
  int mem [256];
  int ops[$], b2s[$];
  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  vector_decode_core i_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .rom_addr_q(rom_addr_q), .rom_rd_q(rom_rd_q), .rom_rdata(rom_rdata),
    .ram_addr_q(ram_addr_q), .ram_rd_q(ram_rd_q), .ram_wr_q(ram_wr_q),
    .ram_wdata_q(ram_wdata_q), .ram_rdata(ram_rdata), .vector_done(vector_done),
    .acc_primary_q(acc_primary_q), .acc_alt_q(acc_alt_q), .negative_flag_q(neg_q),
    .carry_flag_q(cy_q), .equal_flag_q(eq_q), .less_than_flag_q(lt_q),
    .right_shift_flag_q(rs_q), .vector_in_process_flag_q(vt_q), .pc_q(pc_q),
    .prog_addr_q(pa_q));
  mem_model i_mem (.clk(clk), .rom_addr_q(rom_addr_q), .rom_rd_q(rom_rd_q),
    .rom_rdata(rom_rdata), .ram_addr_q(ram_addr_q), .ram_rd_q(ram_rd_q),
    .ram_wr_q(ram_wr_q), .ram_wdata_q(ram_wdata_q), .ram_rdata(ram_rdata));
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input int e, input logic [11:0] g);
    n_compared++;
    if (g !== e[11:0]) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e[11:0]);
    end
  endtask
  // Register port: strobes one cycle, read data only in the following cycle
  task automatic reg_write(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [1:0] a, input int e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    n_compared++;
    if (reg_rdata_q !== e) begin
      n_mismatch++;
      $display("MISMATCH at %0t: register read %h expected %h", $time, reg_rdata_q, e);
    end
  endtask
  // Bounded wait for the fetch of a given program address
  task automatic wait_fetch(input int a);
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      if (rom_rd_q === 1'b1 && rom_addr_q === a[11:0]) return;
    end
    n_mismatch++;
    give_verdict();
  endtask
  // Program bytes per instruction: low nibble zero outside the nibble opcodes
  function automatic int len(input int op);
    return ((op & 15) == 0 && !((op >> 4) inside {1, 6, 7, 8, 9, 'hA})) ? 2 : 1;
  endfunction
  // One instruction of the reference machine
  task automatic model(input int op, input int b2);
    int a, v, r, hi, lo;
    hi = op >> 4;
    lo = op & 15;
    sel = arm;
    arm = (op == 'h57);
    a = sel ? aa : ap;
    r = a;
    v = -1;
    if (hi == 1) pg = lo;
    if (hi == 6 || hi == 7 || hi == 9 || hi == 'hA) wsa = pg * 16 + lo;
    if (hi == 8) begin r = lo << 8; neg = r >> 11; end
    if (hi == 'hA || op == 'hEA) begin r = mem[wsa]; neg = r >> 11; end
    if (hi == 9 || op == 'hEC) mem[wsa] = a;
    if (op == 'hEE) vt = 1;
    if (len(op) == 2 && hi != 2 && hi != 3) pa = hi * 256 + b2;
    if (hi == 2 || hi == 3) v = lo ? lo : b2;
    if (hi == 6 || hi == 7 || op == 'hE7 || op == 'hE8) v = mem[wsa];
    if (v >= 0) begin
      eq = (a == v);
      lt = (v < a);
      if (hi == 2 || hi == 6 || op == 'hE7) begin r = a + v; cy = r >> 12; end
      else begin r = (a - v) & 'hFFF; if (hi != 3 || lo == 0) cy = (a >= v); end
      r = r & 'hFFF;
      neg = r >> 11;
    end
    if (op == 'hE3) begin
      rs = ap & 1;
      ap = (ap >> 1) | ((aa & 1) << 11);
      aa = (aa >> 1) | (aa & 'h800);
      if (rs) aa = (aa + mem[wsa]) & 'hFFF;
      neg = aa >> 11;
    end
    else if (sel) aa = r;
    else ap = r;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int a, n, f;
    void'($urandom(11));
    n = $urandom % 16;
    ops = '{'h10 | $urandom % 16, 'h80 | $urandom % 16, 'h90 | n, 'h21 + $urandom % 15,
      'h20, 'h60 | n, 'h57, 'hEA, 'h30, 'hE8, 'h57, 'h31 + $urandom % 15, 'h57, 'h57,
      'h21 + $urandom % 15, 'hEE, 'hB0, 'h70 | n, 'hA0 | n, 'hE3, 'hEC, 'hE3};
    for (int i = 0; i < 64; i++) i_mem.rom[i] = 8'hFF;  // Idle bytes after the program
    for (int i = 0; i < 256; i++) i_mem.ram[i] = 12'h000;
    a = 0;
    foreach (ops[k]) begin
      b2s.push_back($urandom % 256);
      i_mem.rom[a] = ops[k][7:0];
      i_mem.rom[a + 1] = b2s[k][7:0];
      a += len(ops[k]);
    end
    i_mem.rom[a] = 8'hFF;  // No stray random byte runs after the program
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    reg_write(REG_CTRL, 32'h0000_0001);
    reg_read(REG_CTRL, 1);
    a = 0;
    foreach (ops[k]) begin
      model(ops[k], b2s[k]);
      a += len(ops[k]);
      wait_fetch(a);
      f = vt * 32 + rs * 16 + neg * 8 + cy * 4 + lt * 2 + eq;
      chk(ap, acc_primary_q);
      chk(aa, acc_alt_q);
      chk(f, {6'h00, vt_q, rs_q, neg_q, cy_q, lt_q, eq_q});
      chk(a + 1, pc_q);
      chk(pa, pa_q);
    end
    reg_write(REG_FLAGS, 32'hFFFF_FFFF);
    reg_read(REG_FLAGS, f);
    reg_read(REG_ACCS, aa * 4096 + ap);
    reg_write(REG_CTRL, 32'h0000_0000);
    vector_done <= 1'b1;
    repeat (2) @(posedge clk);
    vector_done <= 1'b0;
    @(negedge clk);
    chk(0, {11'h000, vt_q});
    give_verdict();
  end
endmodule  // vector_cpu_decode_alu_ops_bench
